/* File: core/tws_pkg.sv */
// Package for the three-wire serial port: register map, fields, timing
package tws_pkg;
    // Register addresses as seen by the processor's memory bus
    localparam logic [15:0] TWS_MODE_ADDR = 16'hFF72;
    localparam logic [15:0] TWS_SHIFT_ADDR = 16'hFF73;
    localparam logic [7:0] TWS_MODE_RESET = 8'h00;
    // Field positions in the mode control register
    localparam int TWS_EN_BIT = 7;
    localparam int TWS_RATE_BIT = 4;
    localparam int TWS_ORDER_BIT = 2;
    localparam int TWS_SRC_BIT = 1;
    // Bits software may set; the rest always read zero
    localparam logic [7:0] TWS_MODE_MASK = 8'h96;
    // Internal shift clock dividers: system clock / 4 and / 8
    localparam logic [2:0] TWS_DIV4_HALF = 3'h1;
    localparam logic [2:0] TWS_DIV8_HALF = 3'h3;
    localparam logic [3:0] TWS_BITS = 4'h8;

    // One processor access to the port
    typedef struct packed {
        logic        wr;
        logic        bit_wr;
        logic [2:0]  bit_idx;
        logic        bit_val;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } tws_access_s;

    // Pin drive bundle for one two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } tws_pin_s;
endpackage

/* File: core/tws_clkdiv.sv */
// Shift clock generator: half-period enable pulses from the system clock
`timescale 1ns/100ps
`default_nettype none
module tws_clkdiv (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic div8_i,
    output logic      tick_o
);
    import tws_pkg::*;

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] half_w;
    logic       wrap_w;

    // Half period length chosen by rate select
    assign half_w  = div8_i ? TWS_DIV8_HALF : TWS_DIV4_HALF;
    assign wrap_w  = run_i && (cnt_r == half_w);
    assign cnt_nxt = (!run_i || wrap_w) ? 3'h0 : cnt_r + 3'h1;

    // Count while running; reset when stopped so phase is clean
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_o <= wrap_w;
        end
    end
endmodule
`default_nettype wire

/* File: core/tws_port.sv */
// Three-wire serial port: mode register, shift register, pin control
// Behaviour
// - Port disabled: no transfers, all three pins return to GPIO use.
// - Reset clears the mode control register to zero.
// - Mode register takes single-bit and whole-byte writes.
// - Bit 7 enables the port.
// - Bit 4 picks internal rate: system clock /4 or /8.
// - Bit 1 picks clock source: 0 external pin, 1 internal driven out.
// - Eight-bit transfers; bit 2 picks MSB or LSB first.
// - Falling serial clock latches next bit from the shift register onto data out.
// - Rising serial clock captures data in into the shift register.
// - After eighth bit shifting stops and done request is raised.
// - Shift writes while disabled never start a transfer, even later.
// - With external clock, a second shift write does not change data.
// - Shift write starts transfer when enabled and clock idle high.
// - Shift register content after reset is undefined; this model clears it to zero.
`timescale 1ns/100ps
`default_nettype none
module tws_port (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire tws_pkg::tws_access_s acc_i,
    output logic [7:0]                rdata_o,
    output logic                      busy_o,
    output logic                      transfer_done_irq_o,
    input  wire logic                 serial_clock_pin_i,
    output tws_pkg::tws_pin_s         serial_clock_pin_o,
    output tws_pkg::tws_pin_s         serial_data_out_pin_o,
    input  wire logic                 serial_data_in_pin_i,
    output logic                      port_enable_o
);
    import tws_pkg::*;

    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [3:0] cnt_r;
    logic       busy_r;
    logic       armed_r;
    logic       sck_r;
    logic       so_r;
    logic       sck_m_r;
    logic       sck_s_r;
    logic       sck_d_r;
    logic       si_m_r;
    logic       si_s_r;
    logic [1:0] rise_d_r;
    logic       tick_w;

    wire en_w    = mode_r[TWS_EN_BIT];
    wire int_w   = mode_r[TWS_SRC_BIT];
    wire lsb_w   = mode_r[TWS_ORDER_BIT];
    wire wr_mode = acc_i.wr && (acc_i.addr == TWS_MODE_ADDR);
    wire wr_shft = acc_i.wr && !acc_i.bit_wr
                   && (acc_i.addr == TWS_SHIFT_ADDR);

    // Mode write: byte or single bit, fixed-zero bits masked
    always_comb begin
        mode_nxt = mode_r;
        if (wr_mode && acc_i.bit_wr) begin
            mode_nxt[acc_i.bit_idx] = acc_i.bit_val;
        end else if (wr_mode) begin
            mode_nxt = acc_i.wdata;
        end
        mode_nxt = mode_nxt & TWS_MODE_MASK;
    end

    // Internal clock divider, runs only during internal transfers
    tws_clkdiv tws_clkdiv_i (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (busy_r && int_w),
        .div8_i (mode_r[TWS_RATE_BIT]),
        .tick_o (tick_w)
    );

    // Edge events from either clock source
    wire ext_fall = !int_w && sck_d_r && !sck_s_r;
    wire ext_rise = !int_w && !sck_d_r && sck_s_r;
    wire fall_w   = busy_r && (int_w ? (tick_w && sck_r) : ext_fall);
    wire rise_w   = busy_r && (int_w ? (tick_w && !sck_r) : ext_rise);
    wire idle_ok  = int_w ? 1'b1 : sck_s_r;
    wire start_w  = wr_shft && en_w && !busy_r && idle_ok
                    && !(armed_r && !int_w);
    wire last_w   = rise_w && (cnt_r == TWS_BITS - 4'h1);
    // Internal capture lags the rise so data in has crossed its sync
    wire cap_w    = int_w ? rise_d_r[1] : rise_w;
    wire done_w   = int_w ? (rise_d_r[1] && (cnt_r == TWS_BITS))
                    : last_w;
    wire out_bit  = lsb_w ? shift_nxt[0] : shift_nxt[7];

    // Shift path: load on start, shift and capture data in on rise
    always_comb begin
        shift_nxt = shift_r;
        if (start_w) begin
            shift_nxt = acc_i.wdata;
        end else if (cap_w && lsb_w) begin
            shift_nxt = {si_s_r, shift_r[7:1]};
        end else if (cap_w) begin
            shift_nxt = {shift_r[6:0], si_s_r};
        end else if (wr_shft && !busy_r && !(armed_r && !int_w)) begin
            shift_nxt = acc_i.wdata;
        end
    end

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_m_r <= 1'b1;
            sck_s_r <= 1'b1;
            sck_d_r <= 1'b1;
            si_m_r  <= 1'b0;
            si_s_r  <= 1'b0;
        end else begin
            sck_m_r <= serial_clock_pin_i;
            sck_s_r <= sck_m_r;
            sck_d_r <= sck_s_r;
            si_m_r  <= serial_data_in_pin_i;
            si_s_r  <= si_m_r;
        end
    end

    // Internal rise delayed two cycles to meet the data-in synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_d_r <= 2'h0;
        end else begin
            rise_d_r <= {rise_d_r[0], rise_w && int_w};
        end
    end

    // Mode register and transfer control
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r  <= TWS_MODE_RESET;
            shift_r <= 8'h00;
            busy_r  <= 1'b0;
            armed_r <= 1'b0;
            cnt_r   <= 4'h0;
            sck_r   <= 1'b1;
            so_r    <= 1'b1;
            transfer_done_irq_o <= 1'b0;
        end else begin
            mode_r  <= mode_nxt;
            shift_r <= shift_nxt;
            transfer_done_irq_o <= done_w;
            if (!en_w) begin
                busy_r  <= 1'b0;
                armed_r <= 1'b0;
                sck_r   <= 1'b1;
            end else if (start_w) begin
                busy_r  <= 1'b1;
                armed_r <= 1'b1;
                cnt_r   <= 4'h0;
                so_r    <= acc_i.wdata[lsb_w ? 0 : 7];
            end else begin
                if (int_w && busy_r && tick_w) begin
                    sck_r <= !sck_r;
                end
                if (fall_w && cnt_r != 4'h0) begin
                    so_r <= out_bit;
                end
                if (rise_w) begin
                    cnt_r <= cnt_r + 4'h1;
                end
                if (last_w) begin
                    busy_r  <= 1'b0;
                    armed_r <= 1'b0;
                    sck_r   <= 1'b1;
                end
            end
        end
    end

    // Output latches: pins released when disabled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o               <= 8'h00;
            busy_o                <= 1'b0;
            port_enable_o         <= 1'b0;
            serial_clock_pin_o    <= '{o: 1'b1, oe: 1'b0};
            serial_data_out_pin_o <= '{o: 1'b1, oe: 1'b0};
        end else begin
            rdata_o <= (acc_i.addr == TWS_MODE_ADDR) ? mode_r : shift_r;
            busy_o  <= busy_r;
            port_enable_o <= en_w;
            serial_clock_pin_o <= '{o: sck_r, oe: en_w && int_w};
            serial_data_out_pin_o <= '{o: so_r, oe: en_w};
        end
    end

    // Checks
    chk_irq_after_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_r) && en_w && !int_w |-> transfer_done_irq_o)
        else $error("done request missing at end of transfer");
    chk_irq_int_tail: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_r) && en_w && int_w |-> ##2 transfer_done_irq_o)
        else $error("done request missing after internal transfer");
    chk_disabled_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_w |=> !busy_r)
        else $error("transfer active while disabled");
    chk_clk_released: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_w ##1 !en_w |=> !serial_clock_pin_o.oe)
        else $error("clock pin driven while disabled");
    chk_no_start_off: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_shft && !en_w |=> !busy_r)
        else $error("shift write started transfer while disabled");
    chk_sck_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !busy_r |-> sck_r)
        else $error("internal clock not resting high");
    chk_ext_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        armed_r && !int_w && wr_shft && !rise_w |=> $stable(shift_r))
        else $error("second write changed shift data");
    chk_mode_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r & ~TWS_MODE_MASK) == 8'h00)
        else $error("fixed-zero mode bits set");
    chk_bit_count: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_r |-> cnt_r < TWS_BITS)
        else $error("bit counter exceeded eight");
    cov_int_xfer: cover property (@(posedge clk_i) disable iff (rst_i)
        start_w && int_w ##[1:200] transfer_done_irq_o);
    cov_ext_xfer: cover property (@(posedge clk_i) disable iff (rst_i)
        start_w && !int_w ##[1:1000] transfer_done_irq_o);
    cov_lsb_xfer: cover property (@(posedge clk_i) disable iff (rst_i)
        start_w && lsb_w);
endmodule
`default_nettype wire

/* File: tb/tws_peer.sv */
// Far-side peripheral model: swaps one byte on the line clock
`timescale 1ns/100ps
`default_nettype none
module tws_peer (
    input  wire logic       sck_i,
    input  wire logic       sdo_i,
    input  wire logic [7:0] tx_i,
    input  wire logic       load_i,
    output logic            sdi_o,
    output logic [7:0]      rx_o
);
    logic [7:0] sh_r;
    // Load shows the inverse first; each falling edge puts out a bit
    always @(posedge load_i or negedge sck_i) begin
        if (load_i) begin
            sh_r = tx_i;
            sdi_o = ~tx_i[7];
        end else begin
            sdi_o = sh_r[7];
            sh_r = {sh_r[6:0], 1'b0};
        end
    end
    // Data out is taken on each rising edge; clock is never driven here
    always @(posedge sck_i) begin
        rx_o <= {rx_o[6:0], sdo_i};
    end
endmodule
`default_nettype wire

/* File: tb/tws_port_bench.sv */
// Self-checking bench for the three-wire serial port
`timescale 1ns/100ps
`default_nettype none
module tws_port_bench;
    import tws_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    tws_access_s acc = '0;
    tws_pin_s    sck_pin, sdo_pin;
    logic [7:0]  rdata, prx, v;
    logic [7:0]  ptx = 8'h00;
    logic        busy, irq, en, sdi, sck_w;
    logic        ext_sck = 1'b1;
    logic        load = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    // Clock pin level from whoever drives it
    assign sck_w = (sck_pin.oe === 1'b1) ? sck_pin.o : ext_sck;

    tws_port tws_port_i (.clk_i(clk_i), .rst_i(rst_i), .acc_i(acc),
        .rdata_o(rdata), .busy_o(busy), .transfer_done_irq_o(irq),
        .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_pin),
        .serial_data_out_pin_o(sdo_pin), .serial_data_in_pin_i(sdi),
        .port_enable_o(en));

    tws_peer tws_peer_i (.sck_i(sck_w), .sdo_i(sdo_pin.o), .tx_i(ptx),
        .load_i(load), .sdi_o(sdi), .rx_o(prx));

    always #5 clk_i = ~clk_i;

    // Cut a hang short
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    // Bit write: d[2:0] bit index, d[3] bit value
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic b);
        @(negedge clk_i);
        acc = {1'b1, b, d[2:0], d[3], a, d};
        @(negedge clk_i);
        acc.wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_i);
        acc.addr = a;
        @(negedge clk_i);
        d = rdata;
    endtask

    task automatic reg_access();
        rd(TWS_MODE_ADDR, v);
        cmp("mode reset", 8'h00, v);
        cmp("pins", 8'h00, {5'h00, en, sck_pin.oe, sdo_pin.oe});
        wr(TWS_MODE_ADDR, 8'h96, 1'b0);
        wr(TWS_MODE_ADDR, 8'h07, 1'b1);
        rd(TWS_MODE_ADDR, v);
        cmp("bit clear", 8'h16, v);
        cmp("enable", 8'h00, {7'h00, en});
    endtask

    task automatic disabled_write();
        logic seen;
        seen = 1'b0;
        wr(TWS_MODE_ADDR, 8'h02, 1'b0);
        wr(TWS_SHIFT_ADDR, 8'h5A, 1'b0);
        wr(TWS_MODE_ADDR, 8'h82, 1'b0);
        repeat (60) begin
            @(negedge clk_i);
            seen |= (irq !== 1'b0) | (busy !== 1'b0);
        end
        cmp("no start", 8'h00, {7'h00, seen});
    endtask

    // One transfer; external clock runs 8 pulses of 10 cycles
    task automatic xfer(input logic [7:0] m, d, p);
        int lo;
        lo = 0;
        ptx = p;
        load = 1'b1;
        #1 load = 1'b0;
        wr(TWS_MODE_ADDR, m, 1'b0);
        wr(TWS_SHIFT_ADDR, d, 1'b0);
        if (!m[1]) wr(TWS_SHIFT_ADDR, ~d, 1'b0);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
            @(negedge clk_i);
            if (!m[1]) ext_sck = !(i >= 4 && i < 84 && (i - 4) % 10 < 5);
            lo += (sck_w === 1'b0);
        end
        cmp("done", 8'h01, {7'h00, irq});
        cmp("low cycles", m[1] ? 8'(8 * ((m[4] ? TWS_DIV8_HALF
            : TWS_DIV4_HALF) + 1)) : 8'h28, lo[7:0]);
        cmp("peer rx", m[2] ? {<<{d}} : d, prx);
        rd(TWS_SHIFT_ADDR, v);
        cmp("shift rx", m[2] ? {<<{p}} : p, v);
        cmp("idle", 8'h01, {busy, sck_w});
    endtask

    initial begin
        load = 1'b1;
        #1 load = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        reg_access();
        disabled_write();
        xfer(8'h82, 8'hA5, 8'h3C);
        xfer(8'h92, 8'hC3, 8'h5A);
        xfer(8'h86, 8'h17, 8'hE8);
        xfer(8'h96, 8'h81, 8'h7E);
        xfer(8'h80, 8'h6D, 8'hB2);
        xfer(8'h84, 8'h4B, 8'hD4);
        wr(TWS_MODE_ADDR, 8'h00, 1'b0);
        @(negedge clk_i);
        cmp("released", 8'h00, {5'h00, en, sck_pin.oe, sdo_pin.oe});
        summarize();
    end
endmodule
`default_nettype wire
